//--- rtl/sssw_pkg.sv
// Constants and carrier types for the supply supervisor and stop-mode watchdog control.
// Assumes a 50 MHz internal oscillator clock.
package sssw_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int FILT_NS = 2000;
  localparam logic [7:0] FILT_CYC = 8'((FILT_NS + CLK_NS - 1) / CLK_NS);
  localparam int CCT_NS = 1000;
  localparam logic [7:0] CCT_CYC = 8'((CCT_NS + CLK_NS - 1) / CLK_NS);
  localparam int RD_US = 10;
  localparam logic [9:0] RD_CYC = 10'((RD_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] UV_LAST = 2'h3;

  // ==========================================================================
  // Comparator channels and status flag positions
  localparam int NCH = 8;
  localparam int F_INTERNAL_SUPPLY_UNDER_FLAG = 0;
  localparam int F_INTERNAL_SUPPLY_OVER_FLAG = 1;
  localparam int F_BATTERY_UNDER_FLAG = 2;
  localparam int F_BATTERY_OVER_FLAG = 3;
  localparam int F_HIGHSIDE_SUPPLY_UNDER_FLAG = 4;
  localparam int F_HIGHSIDE_SUPPLY_OVER_FLAG = 5;
  localparam int F_PREWARN = 6;
  localparam int F_REG_UV = 7;
  localparam int F_FAILSAFE = 8;
  localparam int F_POR = 9;
  localparam int NFLAG = 10;
  localparam logic [NFLAG-1:0] FLAG_RST = 10'h200;
  localparam logic [1:0] HB_HS_ON = 2'h1;
  localparam logic [1:0] HB_LS_ON = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {M_INIT, M_NORMAL, M_STOP, M_RESTART, M_FAILSAFE} sssw_mode_e;
  typedef enum logic [1:0] {R_HOLD, R_DELAY, R_RUN} sssw_rst_e;
  typedef enum logic [1:0] {P_RUN, P_TURNOFF, P_OFF} sssw_pw_e;

  typedef struct packed {
    logic vcc_rise_ok;
    logic vcc_rise_hi;
    logic can_wake;
    logic lin_wake;
    logic load_peak;
    logic cp_ok;
    logic pump_under;
    logic vcc_uv;
    logic vcc_warn;
    logic highside_supply_over_flag;
    logic highside_supply_under_flag;
    logic battery_over_flag;
    logic battery_under_flag;
    logic internal_supply_over_flag;
    logic internal_supply_under_flag;
  } sssw_pins_s;

  typedef struct packed {
    logic go_normal;
    logic go_stop;
    logic soft_reset;
    logic wd_trigger;
    logic wr_hardware_control_reg;
    logic arm_first;
    logic wr_watchdog_control_reg;
    logic arm_second;
    logic wr_bus_wake;
    logic bus_wake;
  } sssw_cmd_s;

  typedef struct packed {
    logic pump_enable;
    logic bridge_auto_recovery;
    logic reset_release_hysteresis;
    logic regulator_on;
    logic [3:0][1:0] half_bridge_mode;
  } sssw_cfg_s;

endpackage : sssw_pkg

//--- rtl/sssw_supervisor.sv
// Supply supervision, power-on reset release and stop-mode watchdog arming.
// Assumes asynchronous comparator pins, and host strobes on the clk domain.
`timescale 1ns/1ps
`default_nettype none

module sssw_supervisor (
  input wire logic clk,  // 50 MHz oscillator clock
  input wire logic rst_n,  // Power-on reset, low active
  input wire sssw_pkg::sssw_pins_s pins,  // Comparator and wake pins
  input wire sssw_pkg::sssw_cmd_s cmd,  // Host command strobes
  input wire sssw_pkg::sssw_cfg_s cfg,  // Host configuration levels
  input wire logic [sssw_pkg::NFLAG-1:0] flag_clr,  // Status clear strobes
  output logic [sssw_pkg::NFLAG-1:0] status_flags,  // Latched status flags
  output sssw_pkg::sssw_mode_e mode,  // Device mode
  output logic stop_wdog_arm_first,  // First arming bit
  output logic stop_wdog_arm_second,  // Second arming bit
  output logic bus_wake_wdog_restart,  // Bus wake restart option
  output logic wdog_enabled,  // Watchdog running
  output logic wdog_long_window,  // Long open window start pulse
  output logic wake_irq,  // Bus wake interrupt pulse
  output logic can_receive_out,  // CAN receive, low after wake
  output logic lin_receive_out,  // LIN receive, low after wake
  output logic reset_out_n,  // Reset output, low active
  output logic pump_on,  // Charge pump running
  output logic pump_discharge,  // Passive discharge active
  output logic bridge_enable,  // Bridge driver enabled
  output logic [3:0] bridge_turnoff,  // Active turn-off per half-bridge
  output logic lin_enable,  // LIN transceiver enabled
  output logic sc_diag_enable,  // Regulator short diagnosis enabled
  output logic [1:0] uv_count  // Regulator undervoltage count
);

  // ==========================================================================
  // State
  typedef struct packed {
    sssw_pkg::sssw_pins_s s1;
    sssw_pkg::sssw_pins_s s2;
    logic [sssw_pkg::NCH-1:0][7:0] filt_cnt;
    sssw_pkg::sssw_mode_e mode;
    sssw_pkg::sssw_rst_e rst_st;
    sssw_pkg::sssw_pw_e pw_st;
    logic [9:0] rd_cnt;
    logic [7:0] cct_cnt;
    logic [3:1] cause;
    logic [sssw_pkg::NFLAG-1:0] flag;
    logic [1:0] uv_cnt;
    logic uv_prev;
    logic uv_rst;
    logic arm1;
    logic arm2;
    logic bus_opt;
    logic wdog_on;
    logic lw_start;
    logic wake_irq;
    logic can_rx;
    logic lin_rx;
    logic rst_out_n;
    logic pump_on;
    logic discharge;
    logic bridge_en;
    logic [3:0] bridge_off;
    logic lin_en;
    logic sc_diag;
  } sssw_state_s;

  sssw_state_s q;
  sssw_state_s d;
  logic mon;
  logic [sssw_pkg::NCH-1:0] en;
  logic [sssw_pkg::NCH-1:0] flt;
  logic fault;
  logic rel_ok;
  logic uv_evt;
  logic cnt_act;
  logic wake;
  logic pump_ok;
  logic bridge_ok;

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.lw_start = 1'b0;
    d.wake_irq = 1'b0;
    d.bridge_off = 4'h0;
    mon = q.mode inside {sssw_pkg::M_INIT, sssw_pkg::M_RESTART, sssw_pkg::M_NORMAL};
    en[0] = mon || (q.mode == sssw_pkg::M_STOP && (q.s2.load_peak || q.s2.vcc_warn));
    en[1] = mon;
    en[2] = mon;
    en[3] = mon || cfg.pump_enable;
    en[4] = 1'b1;
    en[5] = 1'b1;
    en[6] = cfg.regulator_on;
    en[7] = cfg.regulator_on;
    for (int i = 0; i < sssw_pkg::NCH; i++) begin
      flt[i] = q.filt_cnt[i] == sssw_pkg::FILT_CYC;
      if (!(q.s2[i] && en[i])) begin
        d.filt_cnt[i] = 8'h0;
      end else if (!flt[i]) begin
        d.filt_cnt[i] = q.filt_cnt[i] + 8'h1;
      end
    end
    fault = flt[1] || flt[2] || flt[3];
    rel_ok = cfg.reset_release_hysteresis ? q.s2.vcc_rise_hi : q.s2.vcc_rise_ok;
    uv_evt = flt[7] && !q.uv_prev;
    d.uv_prev = flt[7];
    cnt_act = q.mode inside {sssw_pkg::M_INIT, sssw_pkg::M_NORMAL, sssw_pkg::M_STOP};
    cnt_act = cnt_act && !(q.mode == sssw_pkg::M_NORMAL && q.s2.battery_under_flag);
    wake = q.s2.can_wake || q.s2.lin_wake;
    pump_ok = !(q.cause[3] && !cfg.bridge_auto_recovery && q.s2.pump_under);
    if (cfg.bridge_auto_recovery) begin
      bridge_ok = q.s2.cp_ok && !q.flag[sssw_pkg::F_BATTERY_UNDER_FLAG];
    end else begin
      bridge_ok = q.flag[3:1] == 3'h0;
    end

    // Clears first; sets below win in the same cycle.
    d.flag = q.flag & ~flag_clr;
    d.sc_diag = !flt[0];
    if (flt[0]) begin
      d.flag[sssw_pkg::F_INTERNAL_SUPPLY_UNDER_FLAG] = 1'b1;
    end
    d.lin_en = !q.s2.highside_supply_under_flag;
    if (flt[4]) begin
      d.flag[sssw_pkg::F_HIGHSIDE_SUPPLY_UNDER_FLAG] = 1'b1;
    end
    if (flt[5]) begin
      d.flag[sssw_pkg::F_HIGHSIDE_SUPPLY_OVER_FLAG] = 1'b1;
    end
    if (flt[6]) begin
      d.flag[sssw_pkg::F_PREWARN] = 1'b1;
    end

    unique case (q.pw_st)
      sssw_pkg::P_RUN: begin
        d.pump_on = cfg.pump_enable;
        d.bridge_en = cfg.pump_enable;
        d.discharge = 1'b0;
        if (fault) begin
          d.pw_st = sssw_pkg::P_TURNOFF;
          d.cause = flt[3:1];
          d.cct_cnt = sssw_pkg::CCT_CYC;
          d.bridge_en = 1'b0;
        end
      end
      sssw_pkg::P_TURNOFF: begin
        d.cause = q.cause | flt[3:1];
        d.cct_cnt = q.cct_cnt - 8'h1;
        for (int i = 0; i < 4; i++) begin
          d.bridge_off[i] = cfg.half_bridge_mode[i] inside {sssw_pkg::HB_HS_ON, sssw_pkg::HB_LS_ON};
        end
        if (q.cct_cnt == 8'h1) begin
          d.pw_st = sssw_pkg::P_OFF;
          d.pump_on = 1'b0;
          d.discharge = 1'b1;
          d.flag[3:1] = d.flag[3:1] | d.cause;
        end
      end
      sssw_pkg::P_OFF: begin
        d.bridge_en = 1'b0;
        if (fault || !cfg.pump_enable) begin
          d.pump_on = 1'b0;
          d.discharge = 1'b1;
          d.cause = q.cause | flt[3:1];
        end else begin
          d.pump_on = pump_ok;
          d.discharge = !pump_ok;
          if (q.pump_on && bridge_ok && !q.flag[sssw_pkg::F_BATTERY_UNDER_FLAG]) begin
            d.pw_st = sssw_pkg::P_RUN;
            d.bridge_en = 1'b1;
            d.cause = 3'h0;
          end
        end
      end
    endcase

    unique case (q.rst_st)
      sssw_pkg::R_HOLD: begin
        if (rel_ok) begin
          d.rst_st = sssw_pkg::R_DELAY;
          d.rd_cnt = sssw_pkg::RD_CYC;
        end
      end
      sssw_pkg::R_DELAY: begin
        d.rd_cnt = q.rd_cnt - 10'h1;
        if (flt[7] || !rel_ok) begin
          d.rst_st = sssw_pkg::R_HOLD;
        end else if (q.rd_cnt == 10'h1) begin
          d.rst_st = sssw_pkg::R_RUN;
          d.rst_out_n = 1'b1;
          d.wdog_on = 1'b1;
          d.lw_start = 1'b1;
          if (q.uv_rst) begin
            d.flag[sssw_pkg::F_REG_UV] = 1'b1;
          end
          d.uv_rst = 1'b0;
          if (q.mode == sssw_pkg::M_RESTART) begin
            d.mode = sssw_pkg::M_NORMAL;
          end
        end
      end
      sssw_pkg::R_RUN: begin
        if (flt[7]) begin
          d.rst_st = sssw_pkg::R_HOLD;
          d.rst_out_n = 1'b0;
          d.uv_rst = 1'b1;
          d.wdog_on = 1'b0;
          d.mode = sssw_pkg::M_RESTART;
        end
      end
      default: begin
        d.rst_st = sssw_pkg::R_HOLD;
      end
    endcase

    if (flag_clr[sssw_pkg::F_REG_UV]) begin
      d.uv_cnt = 2'h0;
    end
    if (uv_evt && cnt_act) begin
      if (q.uv_cnt == sssw_pkg::UV_LAST) begin
        d.mode = sssw_pkg::M_FAILSAFE;
        d.flag[sssw_pkg::F_FAILSAFE] = 1'b1;
        d.uv_cnt = 2'h0;
      end else begin
        d.uv_cnt = q.uv_cnt + 2'h1;
      end
    end

    if (cmd.wr_watchdog_control_reg) begin
      if (q.mode == sssw_pkg::M_NORMAL && cmd.arm_second) begin
        d.arm2 = 1'b1;
        d.arm1 = 1'b0;
      end else begin
        d.arm2 = 1'b0;
      end
    end
    if (cmd.wr_hardware_control_reg) begin
      if (!cmd.arm_first) begin
        d.arm1 = 1'b0;
      end else if (q.mode == sssw_pkg::M_NORMAL && q.arm2) begin
        d.arm1 = 1'b1;
      end else begin
        d.arm2 = 1'b0;
      end
    end
    if (cmd.wr_bus_wake && q.mode == sssw_pkg::M_NORMAL) begin
      d.bus_opt = cmd.bus_wake;
    end
    // A supervisor mode change in the same cycle wins over host stop and normal commands; soft reset wins over it.
    if (cmd.go_stop && q.mode == sssw_pkg::M_NORMAL && d.mode == q.mode) begin
      d.mode = sssw_pkg::M_STOP;
      if (q.arm1 && q.arm2) begin
        d.wdog_on = 1'b0;
      end
    end
    if (q.mode == sssw_pkg::M_STOP) begin
      if (wake) begin
        d.wake_irq = 1'b1;
        d.can_rx = 1'b0;
        d.lin_rx = 1'b0;
      end
      if (!q.wdog_on && (cmd.wd_trigger || (q.bus_opt && wake) || cmd.go_normal)) begin
        d.wdog_on = 1'b1;
        d.lw_start = 1'b1;
        d.arm1 = 1'b0;
        d.arm2 = 1'b0;
      end
    end
    if (cmd.go_normal && q.mode inside {sssw_pkg::M_INIT, sssw_pkg::M_STOP}
        && d.mode == q.mode) begin
      d.mode = sssw_pkg::M_NORMAL;
      d.can_rx = 1'b1;
      d.lin_rx = 1'b1;
    end
    // Soft reset returns to init with defaults.
    if (cmd.soft_reset && q.mode inside {sssw_pkg::M_NORMAL, sssw_pkg::M_STOP}) begin
      d.mode = sssw_pkg::M_INIT;
      d.uv_cnt = 2'h0;
      d.flag = '0;
      d.arm1 = 1'b0;
      d.arm2 = 1'b0;
      d.bus_opt = 1'b1;
      d.can_rx = 1'b1;
      d.lin_rx = 1'b1;
    end
  end

  // ==========================================================================
  // Registers
  // Power-on reset loads every default
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.mode <= sssw_pkg::M_INIT;
      q.rst_st <= sssw_pkg::R_HOLD;
      q.pw_st <= sssw_pkg::P_RUN;
      q.flag <= sssw_pkg::FLAG_RST;
      q.bus_opt <= 1'b1;
      q.can_rx <= 1'b1;
      q.lin_rx <= 1'b1;
      q.lin_en <= 1'b1;
      q.sc_diag <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign status_flags = q.flag;
  assign mode = q.mode;
  assign stop_wdog_arm_first = q.arm1;
  assign stop_wdog_arm_second = q.arm2;
  assign bus_wake_wdog_restart = q.bus_opt;
  assign wdog_enabled = q.wdog_on;
  assign wdog_long_window = q.lw_start;
  assign wake_irq = q.wake_irq;
  assign can_receive_out = q.can_rx;
  assign lin_receive_out = q.lin_rx;
  assign reset_out_n = q.rst_out_n;
  assign pump_on = q.pump_on;
  assign pump_discharge = q.discharge;
  assign bridge_enable = q.bridge_en;
  assign bridge_turnoff = q.bridge_off;
  assign lin_enable = q.lin_en;
  assign sc_diag_enable = q.sc_diag;
  assign uv_count = q.uv_cnt;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  localparam int CCT_I = 60;
  localparam int RD_I = 500;
  int low_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 0;
    end else if (q.rst_out_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  sequence s_fault_hit;
    q.pw_st == sssw_pkg::P_RUN && fault && q.pump_on;
  endsequence

  sequence s_pump_down;
    !q.pump_on && q.discharge;
  endsequence

  a_arm_first_guard: assert property ($rose(q.arm1) |-> q.arm2 && $past(q.mode) == sssw_pkg::M_NORMAL)
    else $error("first arming bit set without second");
  a_seq_err_clear: assert property (cmd.wr_hardware_control_reg && cmd.arm_first && !cmd.wr_watchdog_control_reg
      && q.mode != sssw_pkg::M_NORMAL |=> !q.arm2)
    else $error("sequence error kept second arming bit");
  a_wake_restart: assert property (q.mode == sssw_pkg::M_STOP && !q.wdog_on && q.bus_opt && wake
      && !cmd.soft_reset && !cmd.wr_watchdog_control_reg && !cmd.wr_hardware_control_reg
      |=> q.wdog_on && q.lw_start && !q.arm1 && !q.arm2)
    else $error("bus wake did not restart watchdog");
  a_wake_rx_low: assert property (q.mode == sssw_pkg::M_STOP && wake && !cmd.go_normal
      && !cmd.soft_reset |=> wake_irq && !can_receive_out && !lin_receive_out)
    else $error("bus wake did not signal host");
  a_reset_delay: assert property ($rose(q.rst_out_n) |-> low_cnt >= RD_I)
    else $error("reset released before delay");
  a_shutdown_order: assert property (s_fault_hit |=> !q.bridge_en && q.pump_on
      ##[1:CCT_I] s_pump_down)
    else $error("shutdown order broken");
  a_uv_failsafe: assert property (uv_evt && cnt_act && q.uv_cnt == sssw_pkg::UV_LAST
      && !cmd.soft_reset |=> q.mode == sssw_pkg::M_FAILSAFE
      && q.flag[sssw_pkg::F_FAILSAFE] && q.uv_cnt == 2'h0)
    else $error("fourth undervoltage missed fail-safe");
  a_bridge_battery_under_flag: assert property ($rose(q.bridge_en) |-> !$past(q.flag[sssw_pkg::F_BATTERY_UNDER_FLAG]))
    else $error("bridge enabled with battery undervoltage flag");
  a_lin_highside_supply_under_flag: assert property (q.s2.highside_supply_under_flag |=> !q.lin_en)
    else $error("LIN left on in high-side undervoltage");

endmodule : sssw_supervisor

`default_nettype wire

//--- sim/sssw_host_model.sv
// Host controller model that issues command strobes to the supervisor.
// Assumes the bench clock and that strobes last one clock cycle.
`timescale 1ns/1ps
`default_nettype none

module sssw_host_model (
  input wire logic clk,  // System clock
  input wire logic rst_n,  // Reset, low active
  input wire logic reset_out_n,  // Device reset output
  input wire logic seq_go,  // Start the stop disable sequence
  input wire sssw_pkg::sssw_cmd_s cmd_in,  // Single strobes from the bench
  output var sssw_pkg::sssw_cmd_s cmd  // Strobes to the device
);
  logic [1:0] step_q;
  logic [1:0] step_d;
  sssw_pkg::sssw_cmd_s cmd_d;

  // ==========================================================================
  // Command issue
  always_comb begin
    cmd_d = '0;
    step_d = step_q;
    if (reset_out_n) begin
      // Second bit, first bit, then stop.
      case (step_q)
        2'h1: begin
          cmd_d.wr_watchdog_control_reg = 1'b1;
          cmd_d.arm_second = 1'b1;
          step_d = 2'h2;
        end
        2'h2: begin
          cmd_d.wr_hardware_control_reg = 1'b1;
          cmd_d.arm_first = 1'b1;
          step_d = 2'h3;
        end
        2'h3: begin
          cmd_d.go_stop = 1'b1;
          step_d = 2'h0;
        end
        default: begin
          // Trigger strobes are passed on as written.
          cmd_d = cmd_in;
          if (seq_go) begin
            step_d = 2'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
      step_q <= 2'h0;
    end else begin
      cmd <= cmd_d;
      step_q <= step_d;
    end
  end
endmodule : sssw_host_model

`default_nettype wire

//--- sim/sssw_supervisor_tb.sv
// Self-checking bench for the supply supervisor.
// Assumes a 50 MHz clock and the host model on the command port.
`timescale 1ns/1ps
`default_nettype none

module sssw_supervisor_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic seq_go = 1'b0;
  sssw_pkg::sssw_pins_s pins = '0;
  sssw_pkg::sssw_cmd_s cmd_in = '0;
  sssw_pkg::sssw_cmd_s cmd;
  sssw_pkg::sssw_cmd_s c;
  sssw_pkg::sssw_cfg_s cfg = '0;
  logic [9:0] flag_clr = '0;
  logic [9:0] status_flags;
  sssw_pkg::sssw_mode_e mode;
  logic arm1, arm2, opt, wdog, lw, irq, can_rx, lin_rx, rst_out_n;
  logic pump_on, pump_dis, br_en, lin_en, sc_en;
  logic [3:0] br_off;
  logic [1:0] uv_count;
  int failures = 0;
  int checks_done = 0;

  always #10 clk = ~clk;

  sssw_host_model u_host (.clk(clk), .rst_n(rst_n), .reset_out_n(rst_out_n), .seq_go(seq_go),
    .cmd_in(cmd_in), .cmd(cmd));

  sssw_supervisor u_dut (.clk(clk), .rst_n(rst_n), .pins(pins), .cmd(cmd), .cfg(cfg),
    .flag_clr(flag_clr), .status_flags(status_flags), .mode(mode),
    .stop_wdog_arm_first(arm1), .stop_wdog_arm_second(arm2), .bus_wake_wdog_restart(opt),
    .wdog_enabled(wdog), .wdog_long_window(lw), .wake_irq(irq), .can_receive_out(can_rx),
    .lin_receive_out(lin_rx), .reset_out_n(rst_out_n), .pump_on(pump_on),
    .pump_discharge(pump_dis), .bridge_enable(br_en), .bridge_turnoff(br_off),
    .lin_enable(lin_en), .sc_diag_enable(sc_en), .uv_count(uv_count));

  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic strobe(input sssw_pkg::sssw_cmd_s s);
    @(posedge clk);
    cmd_in <= s;
    @(posedge clk);
    cmd_in <= '0;
    tick(4);
  endtask : strobe

  task automatic clear_flags(input logic [9:0] m);
    @(posedge clk);
    flag_clr <= m;
    @(posedge clk);
    flag_clr <= '0;
    tick(3);
  endtask : clear_flags

  task automatic arm_stop();
    @(posedge clk);
    seq_go <= 1'b1;
    @(posedge clk);
    seq_go <= 1'b0;
    for (int i = 0; i < 20 && mode !== sssw_pkg::M_STOP; i++) @(posedge clk);
    tick(1);
  endtask : arm_stop

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Scenarios
  task automatic t_power_on();
    tick(1);
    chk("flags", 16'h0200, 16'(status_flags));
    chk("option", 16'h1, 16'(opt));
    chk("reset out", 16'h0, 16'(rst_out_n));
    chk("rx outputs", 16'h3, {14'h0, can_rx, lin_rx});
    chk("mode", 16'(sssw_pkg::M_INIT), 16'(mode));
    pins.vcc_rise_ok <= 1'b1;
    tick(400);
    chk("reset held", 16'h0, 16'(rst_out_n));
    for (int i = 0; i < 200 && rst_out_n !== 1'b1; i++) @(posedge clk);
    chk("reset released", 16'h1, 16'(rst_out_n));
    c = '0;
    c.go_normal = 1'b1;
    strobe(c);
    chk("mode", 16'(sssw_pkg::M_NORMAL), 16'(mode));
    clear_flags('1);
    chk("flags cleared", 16'h0, 16'(status_flags));
    $display("test power_on done");
  endtask : t_power_on

  task automatic t_arming();
    c = '0;
    c.wr_hardware_control_reg = 1'b1;
    c.arm_first = 1'b1;
    strobe(c);
    chk("first refused", 16'h0, 16'(arm1));
    arm_stop();
    chk("mode", 16'(sssw_pkg::M_STOP), 16'(mode));
    chk("wdog off", 16'h0, 16'(wdog));
    chk("arms", 16'h3, {14'h0, arm1, arm2});
    c = '0;
    c.wd_trigger = 1'b1;
    strobe(c);
    chk("wdog on", 16'h1, 16'(wdog));
    chk("arms cleared", 16'h0, {14'h0, arm1, arm2});
    c = '0;
    c.go_normal = 1'b1;
    strobe(c);
    $display("test arming done");
  endtask : t_arming

  task automatic t_bus_wake();
    c = '0;
    c.wr_bus_wake = 1'b1;
    strobe(c);
    chk("option off", 16'h0, 16'(opt));
    arm_stop();
    pins.can_wake <= 1'b1;
    for (int i = 0; i < 10 && irq !== 1'b1; i++) @(posedge clk);
    chk("wake irq", 16'h1, 16'(irq));
    pins.can_wake <= 1'b0;
    tick(3);
    chk("rx low", 16'h0, {14'h0, can_rx, lin_rx});
    chk("wdog stays off", 16'h0, 16'(wdog));
    c = '0;
    c.go_normal = 1'b1;
    strobe(c);
    chk("wdog on", 16'h1, 16'(wdog));
    chk("rx high", 16'h3, {14'h0, can_rx, lin_rx});
    c = '0;
    c.wr_bus_wake = 1'b1;
    c.bus_wake = 1'b1;
    strobe(c);
    arm_stop();
    pins.lin_wake <= 1'b1;
    for (int i = 0; i < 10 && wdog !== 1'b1; i++) @(posedge clk);
    chk("wake restart", 16'h1, 16'(wdog));
    pins.lin_wake <= 1'b0;
    c = '0;
    c.go_normal = 1'b1;
    strobe(c);
    $display("test bus_wake done");
  endtask : t_bus_wake

  task automatic t_only_flags();
    int idx[4] = '{0, 4, 5, 6};
    pins.battery_over_flag <= 1'b1;
    tick(60);
    pins.battery_over_flag <= 1'b0;
    tick(110);
    chk("short pulse", 16'h0, 16'(status_flags));
    foreach (idx[k]) begin
      pins[idx[k]] <= 1'b1;
      tick(110);
      chk("single flag", 16'h1 << idx[k], 16'(status_flags));
      chk("diag enable", (idx[k] == 0) ? 16'h0 : 16'h1, 16'(sc_en));
      chk("lin enable", (idx[k] == 4) ? 16'h0 : 16'h1, 16'(lin_en));
      chk("reset out", 16'h1, 16'(rst_out_n));
      pins[idx[k]] <= 1'b0;
      tick(5);
      clear_flags('1);
      chk("flag cleared", 16'h0, 16'(status_flags));
    end
    $display("test only_flags done");
  endtask : t_only_flags

  task automatic t_overvoltage();
    for (int i = 0; i < 50 && br_en !== 1'b1; i++) @(posedge clk);
    chk("pump on", 16'h1, 16'(pump_on));
    chk("bridge on", 16'h1, 16'(br_en));
    pins.internal_supply_over_flag <= 1'b1;
    for (int i = 0; i < 120 && br_en !== 1'b0; i++) @(posedge clk);
    tick(2);
    chk("turnoff", 16'h3, 16'(br_off));
    chk("pump during turnoff", 16'h1, 16'(pump_on));
    for (int i = 0; i < 60 && pump_on !== 1'b0; i++) @(posedge clk);
    tick(1);
    chk("discharge", 16'h1, 16'(pump_dis));
    chk("ov flag", 16'h0002, 16'(status_flags));
    pins.internal_supply_over_flag <= 1'b0;
    tick(10);
    chk("pump restart", 16'h1, 16'(pump_on));
    chk("bridge held", 16'h0, 16'(br_en));
    clear_flags(10'h002);
    chk("bridge back", 16'h1, 16'(br_en));
    $display("test overvoltage done");
  endtask : t_overvoltage

  task automatic t_reg_uv();
    for (int n = 1; n <= 4; n++) begin
      cfg.reset_release_hysteresis <= (n == 2);
      pins.vcc_uv <= 1'b1;
      for (int i = 0; i < 120 && rst_out_n !== 1'b0; i++) @(posedge clk);
      chk("reset low", 16'h0, 16'(rst_out_n));
      chk("uv mode", (n == 4) ? 16'(sssw_pkg::M_FAILSAFE) : 16'(sssw_pkg::M_RESTART), 16'(mode));
      chk("uv count", (n == 4) ? 16'h0 : 16'(n), 16'(uv_count));
      chk("wdog off", 16'h0, 16'(wdog));
      chk("uv flag held", (n == 1) ? 16'h0 : 16'h1, 16'(status_flags[sssw_pkg::F_REG_UV]));
      pins.vcc_uv <= 1'b0;
      if (n == 2) begin
        tick(560);
        chk("hysteresis hold", 16'h0, 16'(rst_out_n));
        pins.vcc_rise_hi <= 1'b1;
      end
      for (int i = 0; i < 600 && rst_out_n !== 1'b1; i++) @(posedge clk);
      chk("reset released", 16'h1, 16'(rst_out_n));
      chk("long window", 16'h1, 16'(lw));
      chk("wdog restarted", 16'h1, 16'(wdog));
      chk("uv flag", 16'h1, 16'(status_flags[sssw_pkg::F_REG_UV]));
      chk("release mode", (n == 4) ? 16'(sssw_pkg::M_FAILSAFE) : 16'(sssw_pkg::M_NORMAL), 16'(mode));
    end
    chk("fail-safe flag", 16'h1, 16'(status_flags[sssw_pkg::F_FAILSAFE]));
    pins.vcc_rise_hi <= 1'b0;
    $display("test reg_uv done");
  endtask : t_reg_uv

  // ==========================================================================
  // Main sequence
  initial begin
    pins.cp_ok <= 1'b1;
    tick(5);
    rst_n <= 1'b1;
    t_power_on();
    t_arming();
    t_bus_wake();
    cfg.regulator_on <= 1'b1;
    t_only_flags();
    cfg.pump_enable <= 1'b1;
    cfg.half_bridge_mode[0] <= sssw_pkg::HB_HS_ON;
    cfg.half_bridge_mode[1] <= sssw_pkg::HB_LS_ON;
    t_overvoltage();
    t_reg_uv();
    end_of_test();
  end

  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule : sssw_supervisor_tb

`default_nettype wire
